/* rtl/twfu_format_unit.sv */
// tagged word format unit: parity, tag decode, fields and unit views
// Notes on behaviour
// - parity bit 51 is one when tag and info hold an even count of ones
// - received words are recounted; any disagreement flags a parity error
// - parity only on module crossings; never shown on user data outputs
// - a word is 52 bits: parity, three tag bits, 48 info bits
// - bits 50..48 are the tag; all eight values decode distinctly
// - info bits numbered upward from zero; bit 47 is most significant
// - a field is first bit (at most 47) and length (at most 48)
// - a field longer than first plus one wraps on to bit 47
// - an even tag marks a data word
// - normal stores may overwrite only even-tagged words
// - single precision is one tag 0 word; double is two tag 2 words
// - an 8-bit character has zone in the upper nibble, digit below
// - packed digits drop the zones and sit side by side
// - info viewed as 12 hex, 16 octal or 6 character units from bit 0
`timescale 1ns/10ps
module twfu_format_unit (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // outgoing transfer
    input  wire logic        i_tx_valid,
    input  wire logic [2:0]  i_tx_tag,
    input  wire logic [47:0] i_tx_info,
    output logic             o_tx_valid,
    output logic      [51:0] o_tx_word,
    // incoming transfer
    input  wire logic        i_rx_valid,
    input  wire logic [51:0] i_rx_word,
    output logic             o_rx_valid,
    output logic      [2:0]  o_rx_tag,
    output logic      [47:0] o_rx_info,
    output logic      [7:0]  o_tag_onehot,
    output logic             o_is_data,
    output logic             o_is_sp,
    output logic             o_is_dp,
    output logic             o_rx_par_err,
    input  wire logic        i_err_clr,
    output logic             o_par_err_sticky,
    // store protection
    input  wire logic        i_st_valid,
    input  wire logic        i_st_overwrite,
    input  wire logic [2:0]  i_st_old_tag,
    output logic             o_st_valid,
    output logic             o_st_allow,
    // field extraction
    input  wire logic        i_fx_valid,
    input  wire logic [5:0]  i_fx_first,
    input  wire logic [5:0]  i_fx_len,
    input  wire logic [47:0] i_fx_info,
    output logic             o_fx_valid,
    output logic             o_fx_bad,
    output logic      [47:0] o_fx_field,
    // unit views
    input  wire logic        i_uv_valid,
    input  wire logic [1:0]  i_uv_mode,
    input  wire logic [3:0]  i_uv_index,
    input  wire logic [47:0] i_uv_info,
    output logic             o_uv_valid,
    output logic             o_uv_bad,
    output logic      [7:0]  o_uv_unit,
    output logic      [3:0]  o_uv_zone,
    output logic      [3:0]  o_uv_digit,
    output logic      [23:0] o_uv_packed
);
    localparam int TH = twfu_pkg::TAG_HI;
    localparam int TL = twfu_pkg::TAG_LO;
    localparam int IM = twfu_pkg::INFO_MSB;
    localparam int PB = twfu_pkg::PAR_BIT;
    localparam int ZW = twfu_pkg::ZONE_W;
    localparam int CW = twfu_pkg::CHAR_W;
    localparam logic [5:0] FIRST_MAX = 6'(twfu_pkg::INFO_MSB);
    localparam logic [5:0] LEN_MAX   = 6'(twfu_pkg::INFO_W);

    // transmit side: odd parity over the whole word
    wire        tx_par  = ~^{i_tx_tag, i_tx_info};
    wire [51:0] tx_word = {tx_par, i_tx_tag, i_tx_info};

    // receive side
    wire [2:0]  rx_tag  = i_rx_word[TH:TL];
    wire [47:0] rx_info = i_rx_word[IM:0];
    wire        rx_bad  = (^i_rx_word[TH:0]) == i_rx_word[PB];
    wire        par_hit = i_rx_valid && rx_bad;
    wire        rx_dp   = i_rx_valid && rx_tag == twfu_pkg::TAG_DP;
    logic [7:0] tag_dec;

    genvar t;
    generate
        for (t = 0; t < twfu_pkg::NUM_TAGS; t++)
        begin : g_tag
            assign tag_dec[t] = rx_tag == 3'(t);
        end
    endgenerate

    // pairing of double precision halves
    twfu_pkg::twfu_dp_e dp_q, dp_d;
    always_comb
    begin
        dp_d = dp_q;
        case (dp_q)
            twfu_pkg::twfu_dp_idle:
                if (rx_dp)
                    dp_d = twfu_pkg::twfu_dp_half;
            twfu_pkg::twfu_dp_half:
                if (i_rx_valid)
                    dp_d = twfu_pkg::twfu_dp_idle;
            default:
                dp_d = twfu_pkg::twfu_dp_idle;
        endcase
    end
    wire dp_pair = dp_q == twfu_pkg::twfu_dp_half && rx_dp;

    // sticky error: a new error wins over the clear
    wire sticky_d = par_hit || (o_par_err_sticky && !i_err_clr);

    // store protection
    wire st_ok = i_st_overwrite || !i_st_old_tag[0];

    // field extraction
    wire [47:0] fx_raw;
    wire [5:0]  fx_lsb;
    wire        fx_bad = i_fx_first > FIRST_MAX || i_fx_len > LEN_MAX;
    twfu_field_extract #(
        .INFO_W (twfu_pkg::INFO_W),
        .SEL_W  (twfu_pkg::SEL_W)
    ) u_fx (
        .i_first (i_fx_first),
        .i_len   (i_fx_len),
        .i_info  (i_fx_info),
        .o_field (fx_raw),
        .o_lsb   (fx_lsb)
    );
    wire [47:0] fx_field = fx_bad ? '0 : fx_raw;

    // unit views, all aligned from bit zero
    wire is_hex  = i_uv_mode == twfu_pkg::twfu_view_hex;
    wire is_oct  = i_uv_mode == twfu_pkg::twfu_view_oct;
    wire is_chr  = i_uv_mode == twfu_pkg::twfu_view_char;
    wire [5:0] uv_sh = is_hex ? 6'(i_uv_index * twfu_pkg::HEX_W)
                     : is_oct ? 6'(i_uv_index * twfu_pkg::OCT_W)
                     : 6'(i_uv_index * twfu_pkg::CHAR_W);
    wire [7:0] uv_mask = is_hex ? 8'h0f : is_oct ? 8'h07 : 8'hff;
    wire [47:0] uv_shf = i_uv_info >> uv_sh;
    wire [7:0] uv_unit = uv_shf[7:0] & uv_mask;
    wire uv_bad = is_hex ? i_uv_index >= 4'(twfu_pkg::NUM_HEX)
                : is_chr ? i_uv_index >= 4'(twfu_pkg::NUM_CHAR)
                : !is_oct;
    logic [23:0] packed_d;

    genvar c;
    generate
        for (c = 0; c < twfu_pkg::NUM_CHAR; c++)
        begin : g_pack
            // numeric nibble of each character only
            assign packed_d[c*ZW +: ZW] = i_uv_info[c*CW +: ZW];
        end
    endgenerate

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_tx_valid       <= 1'b0;
            o_tx_word        <= '0;
            o_rx_valid       <= 1'b0;
            o_rx_tag         <= '0;
            o_rx_info        <= '0;
            o_tag_onehot     <= '0;
            o_is_data        <= 1'b0;
            o_is_sp          <= 1'b0;
            o_is_dp          <= 1'b0;
            o_rx_par_err     <= 1'b0;
            o_par_err_sticky <= 1'b0;
            dp_q             <= twfu_pkg::twfu_dp_idle;
        end
        else
        begin
            o_tx_valid       <= i_tx_valid;
            o_tx_word        <= i_tx_valid ? tx_word : o_tx_word;
            o_rx_valid       <= i_rx_valid;
            o_rx_tag         <= i_rx_valid ? rx_tag : o_rx_tag;
            o_rx_info        <= i_rx_valid ? rx_info : o_rx_info;
            o_tag_onehot     <= i_rx_valid ? tag_dec : '0;
            o_is_data        <= i_rx_valid && !rx_tag[0];
            o_is_sp          <= i_rx_valid && rx_tag == twfu_pkg::TAG_SP;
            o_is_dp          <= dp_pair;
            o_rx_par_err     <= par_hit;
            o_par_err_sticky <= sticky_d;
            dp_q             <= dp_d;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_st_valid  <= 1'b0;
            o_st_allow  <= 1'b0;
            o_fx_valid  <= 1'b0;
            o_fx_bad    <= 1'b0;
            o_fx_field  <= '0;
            o_uv_valid  <= 1'b0;
            o_uv_bad    <= 1'b0;
            o_uv_unit   <= '0;
            o_uv_zone   <= '0;
            o_uv_digit  <= '0;
            o_uv_packed <= '0;
        end
        else
        begin
            o_st_valid <= i_st_valid;
            o_st_allow <= i_st_valid && st_ok;
            o_fx_valid <= i_fx_valid;
            o_fx_bad   <= i_fx_valid && fx_bad;
            o_uv_valid <= i_uv_valid;
            o_uv_bad   <= i_uv_valid && uv_bad;
            if (i_fx_valid)
                o_fx_field <= fx_field;
            if (i_uv_valid)
            begin
                o_uv_unit   <= uv_bad ? '0 : uv_unit;
                o_uv_zone   <= uv_unit[CW-1:ZW];
                o_uv_digit  <= uv_unit[ZW-1:0];
                o_uv_packed <= packed_d;
            end
        end
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    tx_parity_a: assert property (i_tx_valid |=> o_tx_valid &&
        (^o_tx_word) && o_tx_word[PB] == ~^$past({i_tx_tag, i_tx_info}))
        else $error("transmit parity wrong");
    rx_check_a: assert property (i_rx_valid |=>
        o_rx_par_err == ~(^$past(i_rx_word)))
        else $error("receive parity check wrong");
    rx_fields_a: assert property (i_rx_valid |=>
        o_rx_info == $past(i_rx_word[IM:0])
        && o_rx_tag == $past(i_rx_word[TH:TL]))
        else $error("receive split wrong");
    tag_decode_a: assert property (o_rx_valid |->
        $onehot(o_tag_onehot) && o_tag_onehot[o_rx_tag])
        else $error("tag decode not one hot");
    data_class_a: assert property (o_rx_valid |->
        o_is_data == !o_rx_tag[0]
        && o_is_sp == (o_rx_tag == twfu_pkg::TAG_SP))
        else $error("data class wrong");
    dp_pair_a: assert property (o_is_dp |->
        o_rx_tag == twfu_pkg::TAG_DP && $past(dp_q) != dp_q)
        else $error("double pair wrong");
    store_gate_a: assert property (i_st_valid |=> o_st_allow ==
        ($past(i_st_overwrite) || !$past(i_st_old_tag[0])))
        else $error("store protection wrong");
    fx_low_bit_a: assert property (i_fx_valid && !fx_bad
        && i_fx_len != '0 |=> o_fx_field[0] == $past(i_fx_info[fx_lsb]))
        else $error("field low bit wrong");
    fx_fill_a: assert property (i_fx_valid |=>
        (o_fx_field >> $past(i_fx_len)) == '0)
        else $error("field not zero filled");
    fx_range_a: assert property (i_fx_valid && fx_bad |=>
        o_fx_bad && o_fx_field == '0)
        else $error("bad selector not flagged");
    pack_a: assert property (i_uv_valid |=>
        o_uv_packed[ZW-1:0] == $past(i_uv_info[ZW-1:0])
        && o_uv_packed[2*ZW-1:ZW] == $past(i_uv_info[CW+ZW-1:CW]))
        else $error("packed digits wrong");
    sticky_hold_a: assert property (o_par_err_sticky && !i_err_clr
        && !par_hit |=> o_par_err_sticky [*2] or i_err_clr ##1 1'b1)
        else $error("sticky error lost");
    sticky_set_a: assert property (par_hit |=> o_par_err_sticky)
        else $error("error not latched");
    sticky_clear_a: assert property (i_err_clr && !par_hit |=>
        !o_par_err_sticky)
        else $error("sticky error not cleared");
    idle_tag_a: assert property (!o_rx_valid |-> o_tag_onehot == '0)
        else $error("tag decode shown while idle");
    tx_hold_a: assert property (!i_tx_valid |=> $stable(o_tx_word))
        else $error("transmit word not held");
    uv_hex_a: assert property (i_uv_valid && is_hex && !uv_bad |=>
        o_uv_unit == 8'($past(
            i_uv_info[i_uv_index*twfu_pkg::HEX_W +: twfu_pkg::HEX_W])))
        else $error("hex digit wrong");
    uv_oct_a: assert property (i_uv_valid && is_oct |=>
        o_uv_unit == 8'($past(
            i_uv_info[i_uv_index*twfu_pkg::OCT_W +: twfu_pkg::OCT_W])))
        else $error("octal digit wrong");
    uv_chr_a: assert property (i_uv_valid && is_chr && !uv_bad |=>
        o_uv_unit == $past(i_uv_info[i_uv_index*CW +: CW]))
        else $error("character unit wrong");
    uv_layout_a: assert property (o_uv_valid && !o_uv_bad |->
        o_uv_unit == {o_uv_zone, o_uv_digit})
        else $error("zone and digit split wrong");
    uv_bad_zero_a: assert property (o_uv_bad |-> o_uv_unit == '0)
        else $error("bad view not zeroed");

    parity_err_c: cover property (i_rx_valid && rx_bad ##1 i_err_clr);
    dp_pair_c: cover property (o_is_dp);
    fx_wrap_c: cover property (i_fx_valid && !fx_bad
        && {1'b0, i_fx_len} > {1'b0, i_fx_first} + 7'h01);
    uv_char_c: cover property (i_uv_valid && is_chr && !uv_bad);
    uv_bad_c: cover property (i_uv_valid && uv_bad);
endmodule

/* rtl/twfu_pkg.sv */
// constants and types of the tagged word format unit
package twfu_pkg;
    localparam int WORD_W   = 52;
    localparam int INFO_W   = 48;
    localparam int TAG_W    = 3;
    localparam int PAR_BIT  = 51;
    localparam int TAG_HI   = 50;
    localparam int TAG_LO   = 48;
    localparam int INFO_MSB = 47;
    localparam int SEL_W    = 6;
    localparam int NUM_TAGS = 8;
    localparam int HEX_W    = 4;
    localparam int OCT_W    = 3;
    localparam int CHAR_W   = 8;
    localparam int ZONE_W   = 4;
    localparam int NUM_HEX  = 12;
    localparam int NUM_OCT  = 16;
    localparam int NUM_CHAR = 6;
    localparam int PACK_W   = NUM_CHAR * ZONE_W;
    localparam logic [2:0] TAG_SP = 3'h0;
    localparam logic [2:0] TAG_DP = 3'h2;

    typedef enum logic [1:0] {
        twfu_view_hex,
        twfu_view_oct,
        twfu_view_char
    } twfu_view_e;

    typedef enum logic {
        twfu_dp_idle,
        twfu_dp_half
    } twfu_dp_e;
endpackage

/* rtl/twfu_field_extract.sv */
// [first:length] field extractor with wrap past bit zero
`timescale 1ns/10ps
module twfu_field_extract #(
    parameter int INFO_W = 48,
    parameter int SEL_W  = 6
) (
    input  wire logic [SEL_W-1:0]  i_first,
    input  wire logic [SEL_W-1:0]  i_len,
    input  wire logic [INFO_W-1:0] i_info,
    output logic      [INFO_W-1:0] o_field,
    output logic      [SEL_W-1:0]  o_lsb
);
    localparam logic [SEL_W:0] INFO_N = (SEL_W+1)'(INFO_W);

    wire [SEL_W:0]      top_n  = {1'b0, i_first} + (SEL_W+1)'(1);
    wire [SEL_W:0]      len_n  = {1'b0, i_len};
    wire                wraps  = len_n > top_n;
    // lowest bit of the field; wrapped fields start high
    wire [SEL_W:0]      lsb_n  = wraps ? top_n + INFO_N - len_n
                                       : top_n - len_n;
    wire [2*INFO_W-1:0] dbl    = {i_info, i_info};
    wire [2*INFO_W-1:0] shf    = dbl >> lsb_n;
    logic [INFO_W-1:0]  mask;

    genvar b;
    generate
        for (b = 0; b < INFO_W; b++)
        begin : g_mask
            assign mask[b] = len_n > (SEL_W+1)'(b);
        end
    endgenerate

    assign o_field = shf[INFO_W-1:0] & mask;
    assign o_lsb   = lsb_n[SEL_W-1:0];
endmodule

/* testbench/twfu_peer_model.sv */
// far-side module model: sends words over the path, checks sent parity
`timescale 1ns/10ps
module twfu_peer_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_send,
    input  wire logic [2:0]  i_tag,
    input  wire logic [47:0] i_info,
    input  wire logic        i_corrupt,
    input  wire logic        i_tx_valid,
    input  wire logic [51:0] i_tx_word,
    output logic             o_rx_valid,
    output logic      [51:0] o_rx_word,
    output logic             o_par_ok
);
    // odd word parity; corrupt flips the parity bit only
    wire logic par_bit = ~^{i_tag, i_info} ^ i_corrupt;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_rx_valid <= 1'b0;
            o_rx_word  <= 52'h0;
            o_par_ok   <= 1'b0;
        end
        else
        begin
            o_rx_valid <= i_send;
            // idle path inverts the stale data every cycle, so it shows the last word every second cycle
            o_rx_word  <= i_send ? {par_bit, i_tag, i_info} : ~o_rx_word;
            if (i_tx_valid)
                o_par_ok <= ^i_tx_word;
        end
    end
endmodule

/* testbench/twfu_format_unit_tb.sv */
// self-checking bench of the tagged word format unit
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module twfu_format_unit_tb;
    logic        i_clk, i_rst, i_tx_valid, i_rx_valid, i_err_clr;
    logic        i_st_valid, i_st_overwrite, i_fx_valid, i_uv_valid;
    logic        o_tx_valid, o_rx_valid, o_is_data, o_is_sp, o_is_dp;
    logic        o_rx_par_err, o_par_err_sticky, o_st_valid, o_st_allow;
    logic        o_fx_valid, o_fx_bad, o_uv_valid, o_uv_bad;
    logic        p_send, p_corrupt, p_ok;
    logic [2:0]  i_tx_tag, o_rx_tag, i_st_old_tag, p_tag;
    logic [47:0] i_tx_info, o_rx_info, i_fx_info, o_fx_field;
    logic [47:0] i_uv_info, p_info;
    logic [51:0] o_tx_word, i_rx_word;
    logic [7:0]  o_tag_onehot, o_uv_unit;
    logic [5:0]  i_fx_first, i_fx_len;
    logic [3:0]  i_uv_index, o_uv_zone, o_uv_digit;
    logic [1:0]  i_uv_mode;
    logic [23:0] o_uv_packed;
    int          err_count = 0;
    int          num_checks = 0;

    twfu_format_unit u_dut (
        .i_clk            (i_clk),
        .i_rst            (i_rst),
        .i_tx_valid       (i_tx_valid),
        .i_tx_tag         (i_tx_tag),
        .i_tx_info        (i_tx_info),
        .o_tx_valid       (o_tx_valid),
        .o_tx_word        (o_tx_word),
        .i_rx_valid       (i_rx_valid),
        .i_rx_word        (i_rx_word),
        .o_rx_valid       (o_rx_valid),
        .o_rx_tag         (o_rx_tag),
        .o_rx_info        (o_rx_info),
        .o_tag_onehot     (o_tag_onehot),
        .o_is_data        (o_is_data),
        .o_is_sp          (o_is_sp),
        .o_is_dp          (o_is_dp),
        .o_rx_par_err     (o_rx_par_err),
        .i_err_clr        (i_err_clr),
        .o_par_err_sticky (o_par_err_sticky),
        .i_st_valid       (i_st_valid),
        .i_st_overwrite   (i_st_overwrite),
        .i_st_old_tag     (i_st_old_tag),
        .o_st_valid       (o_st_valid),
        .o_st_allow       (o_st_allow),
        .i_fx_valid       (i_fx_valid),
        .i_fx_first       (i_fx_first),
        .i_fx_len         (i_fx_len),
        .i_fx_info        (i_fx_info),
        .o_fx_valid       (o_fx_valid),
        .o_fx_bad         (o_fx_bad),
        .o_fx_field       (o_fx_field),
        .i_uv_valid       (i_uv_valid),
        .i_uv_mode        (i_uv_mode),
        .i_uv_index       (i_uv_index),
        .i_uv_info        (i_uv_info),
        .o_uv_valid       (o_uv_valid),
        .o_uv_bad         (o_uv_bad),
        .o_uv_unit        (o_uv_unit),
        .o_uv_zone        (o_uv_zone),
        .o_uv_digit       (o_uv_digit),
        .o_uv_packed      (o_uv_packed)
    );

    twfu_peer_model u_peer (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_send     (p_send),
        .i_tag      (p_tag),
        .i_info     (p_info),
        .i_corrupt  (p_corrupt),
        .i_tx_valid (o_tx_valid),
        .i_tx_word  (o_tx_word),
        .o_rx_valid (i_rx_valid),
        .o_rx_word  (i_rx_word),
        .o_par_ok   (p_ok)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    function automatic logic [47:0] fx_ref(int f, int l, logic [47:0] d);
        logic [47:0] r;
        r = '0;
        if (f > 47 || l > 48)
            return r;
        for (int i = 0; i < l; i++)
            r[l-1-i] = d[(f - i + 48) % 48];
        return r;
    endfunction

    task automatic tx_one(logic [2:0] t, logic [47:0] d);
        @(posedge i_clk);
        i_tx_valid <= 1'b1;
        i_tx_tag   <= t;
        i_tx_info  <= d;
        @(posedge i_clk);
        i_tx_valid <= 1'b0;
        #1;
        `CHK("tx_valid", 1'b1, o_tx_valid)
        `CHK("tx_word", {~^{t, d}, t, d}, o_tx_word)
        @(posedge i_clk);
        #1;
        `CHK("peer_parity", 1'b1, p_ok)
    endtask

    task automatic rx_one(logic [2:0] t, logic [47:0] d, logic bad,
                          logic clr, logic dp, logic st);
        @(posedge i_clk);
        p_send    <= 1'b1;
        p_tag     <= t;
        p_info    <= d;
        p_corrupt <= bad;
        @(posedge i_clk);
        p_send    <= 1'b0;
        i_err_clr <= clr;
        @(posedge i_clk);
        i_err_clr <= 1'b0;
        #1;
        `CHK("rx_valid", 1'b1, o_rx_valid)
        `CHK("rx_tag", t, o_rx_tag)
        `CHK("rx_info", d, o_rx_info)
        `CHK("tag_onehot", 8'h01 << t, o_tag_onehot)
        `CHK("is_data", ~t[0], o_is_data)
        `CHK("is_sp", t == 3'h0, o_is_sp)
        `CHK("is_dp", dp, o_is_dp)
        `CHK("par_err", bad, o_rx_par_err)
        `CHK("sticky", st, o_par_err_sticky)
    endtask

    task automatic fx_one(int f, int l, logic [47:0] d);
        @(posedge i_clk);
        i_fx_valid <= 1'b1;
        i_fx_first <= 6'(f);
        i_fx_len   <= 6'(l);
        i_fx_info  <= d;
        @(posedge i_clk);
        i_fx_valid <= 1'b0;
        #1;
        `CHK("fx_valid", 1'b1, o_fx_valid)
        `CHK("fx_bad", f > 47 || l > 48, o_fx_bad)
        `CHK("fx_field", fx_ref(f, l, d), o_fx_field)
    endtask

    task automatic st_one(logic ow, logic [2:0] tg);
        @(posedge i_clk);
        i_st_valid     <= 1'b1;
        i_st_overwrite <= ow;
        i_st_old_tag   <= tg;
        @(posedge i_clk);
        i_st_valid     <= 1'b0;
        #1;
        `CHK("st_valid", 1'b1, o_st_valid)
        `CHK("st_allow", ow | ~tg[0], o_st_allow)
    endtask

    task automatic uv_one(int m, int x, logic [47:0] d);
        logic [7:0]  e;
        logic [23:0] pk;
        logic        bad;
        logic [7:0]  ez;
        bad = m == 3 || (m == 0 && x >= 12) || (m == 2 && x >= 6);
        e = 8'h00;
        if (m == 0 && x < 12)
            e = {4'h0, d[4*x +: 4]};
        if (m == 1)
            e = {5'h00, d[3*x +: 3]};
        if (m == 2 && x < 6)
            e = d[8*x +: 8];
        for (int i = 0; i < 6; i++)
            pk[4*i +: 4] = d[8*i +: 4];
        // zone and digit follow the unit before bad views are zeroed
        ez = e;
        if (m == 3 || (m == 2 && x >= 6))
            ez = (x % 8 < 6) ? d[8*(x%8) +: 8] : 8'h00;
        @(posedge i_clk);
        i_uv_valid <= 1'b1;
        i_uv_mode  <= 2'(m);
        i_uv_index <= 4'(x);
        i_uv_info  <= d;
        @(posedge i_clk);
        i_uv_valid <= 1'b0;
        #1;
        `CHK("uv_valid", 1'b1, o_uv_valid)
        `CHK("uv_bad", bad, o_uv_bad)
        `CHK("uv_unit", e, o_uv_unit)
        `CHK("uv_zone", ez[7:4], o_uv_zone)
        `CHK("uv_digit", ez[3:0], o_uv_digit)
        `CHK("uv_packed", pk, o_uv_packed)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        $display("unexpected timeout exp %h got %h", 1'b0, 1'b1);
        print_verdict();
    end

    initial
    begin
        i_rst = 1'b1;
        {i_tx_valid, i_err_clr, i_st_valid, i_st_overwrite, i_fx_valid,
         i_uv_valid, p_send, p_corrupt, i_tx_tag, i_tx_info, i_st_old_tag,
         i_fx_first, i_fx_len, i_fx_info, i_uv_mode, i_uv_index,
         i_uv_info, p_tag, p_info} = '0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        `CHK("reset_sticky", 1'b0, o_par_err_sticky)
        `CHK("reset_tx_word", 52'h0, o_tx_word)
        for (int t = 0; t < 8; t++)
            tx_one(3'(t), {16{3'(t)}} ^ 48'h8000_0000_0001);
        tx_one(3'h0, 48'h0);
        $display("transmit test finished");
        for (int t = 0; t < 8; t++)
            rx_one(3'(t), {16{3'(t)}}, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_one(3'h0, 48'h1, 1'b1, 1'b0, 1'b0, 1'b1);
        rx_one(3'h4, 48'h3, 1'b0, 1'b0, 1'b0, 1'b1);
        rx_one(3'h6, 48'h7, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_one(3'h1, 48'hf, 1'b1, 1'b1, 1'b0, 1'b1);
        rx_one(3'h0, 48'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("receive and parity test finished");
        rx_one(3'h2, 48'ha, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_one(3'h2, 48'hb, 1'b0, 1'b0, 1'b1, 1'b0);
        rx_one(3'h2, 48'hc, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_one(3'h0, 48'hd, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_one(3'h2, 48'he, 1'b0, 1'b0, 1'b0, 1'b0);
        rx_one(3'h2, 48'hf, 1'b0, 1'b0, 1'b1, 1'b0);
        $display("double precision test finished");
        for (int k = 0; k < 16; k++)
            st_one(k[3], k[2:0]);
        $display("store protection test finished");
        fx_one(3, 6, 48'h8000_0000_000f);
        fx_one(47, 48, 48'hc3a5_0f1e_9d27);
        fx_one(0, 48, 48'hc3a5_0f1e_9d27);
        fx_one(10, 25, 48'hc3a5_0f1e_9d27);
        fx_one(47, 1, 48'h8000_0000_0000);
        fx_one(20, 0, 48'hffff_ffff_ffff);
        fx_one(48, 1, 48'hffff_ffff_ffff);
        fx_one(5, 49, 48'hffff_ffff_ffff);
        $display("field extract test finished");
        for (int m = 0; m < 4; m++)
            for (int x = 0; x < 16; x++)
                uv_one(m, x, 48'h5a3c_96e1_f512);
        $display("unit view test finished");
        print_verdict();
    end
endmodule
